/* spg_pkg.sv */
// package of constants and types for the stall prevention governor
package spg_pkg;
  localparam int FREQ_W = 16;
  localparam int MEAS_W = 16;
  localparam int LEVEL_W = 10;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 10'h096;
  localparam logic [1:0] QSEL_TORQUE = 2'h1;
  localparam logic [1:0] QSEL_RESET = 2'h0;
  localparam int RAMP_PERIOD_US = 10;
  localparam int CLK_MHZ = 100;
  localparam int RAMP_CYCLES = RAMP_PERIOD_US * CLK_MHZ;
  localparam logic [FREQ_W-1:0] FREQ_STEP = 16'h0001;

  typedef enum logic [2:0] {
    SPG_IDLE = 3'b000,
    SPG_ACC = 3'b001,
    SPG_ACC_HOLD = 3'b010,
    SPG_CONST = 3'b011,
    SPG_CONST_DROP = 3'b100,
    SPG_DEC = 3'b101,
    SPG_DEC_HOLD = 3'b110
  } spg_state_e;
endpackage : spg_pkg

/* spg_cmp_if.sv */
// interface carrying overload compare inputs and result
`timescale 1ns/100ps
interface spg_cmp_if;
  logic [spg_pkg::MEAS_W-1:0] current;
  logic [spg_pkg::MEAS_W-1:0] torque;
  logic [1:0] quantity_sel;
  logic [spg_pkg::LEVEL_W-1:0] level;
  logic overload;
  modport gov (output current, output torque, output quantity_sel, output level, input overload);
  modport det (input current, input torque, input quantity_sel, input level, output overload);
endinterface : spg_cmp_if

/* spg_overload_det.sv */
// overload detector: selects monitored quantity, compares with level
`timescale 1ns/100ps
module spg_overload_det (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  spg_cmp_if.det cmp
);
  logic [spg_pkg::MEAS_W-1:0] monitored;
  logic above;
  logic overload;
  // percent of rating, equality keeps the previous state
  assign monitored = (cmp.quantity_sel == spg_pkg::QSEL_TORQUE) ? cmp.torque : cmp.current; // RULE_02
  assign above = monitored > spg_pkg::MEAS_W'(cmp.level);
  assign cmp.overload = overload;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overload <= 1'b0;
    end else if (above) begin
      overload <= 1'b1; // RULE_01
    end else if (monitored < spg_pkg::MEAS_W'(cmp.level)) begin
      overload <= 1'b0; // RULE_01
    end
  end

  a_overload_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_01
    above |=> overload) else $error("overload not flagged");
  a_overload_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_01
    (monitored < spg_pkg::MEAS_W'(cmp.level)) |=> !overload) else $error("overload not cleared");
endmodule : spg_overload_det

/* spg_governor.sv */
// stall prevention governor: ramps output frequency, holds or drops on overload
// Operation
// RULE_01: overload present while monitored quantity exceeds level, cleared once below it.
// RULE_02: quantity select equal to one monitors torque, otherwise current.
// RULE_03: accelerating with overload holds the output frequency.
// RULE_04: after overload clears, acceleration ramp resumes.
// RULE_05: constant speed with overload lowers the output frequency.
// RULE_06: after overload clears, frequency rises back to the set frequency.
// RULE_07: decelerating with overload holds the output frequency.
// RULE_08: after overload clears, deceleration ramp resumes.
// RULE_09: the warning never shuts off the drive output.
// RULE_10: level setting defaults to 150 percent after reset.
// RULE_11: warning indication shown while any hold or reduce action is in effect.
`timescale 1ns/100ps
module spg_governor #(
  parameter int FREQ_W = spg_pkg::FREQ_W,
  parameter int MEAS_W = spg_pkg::MEAS_W,
  parameter int RAMP_CYCLES = spg_pkg::RAMP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic [FREQ_W-1:0] set_freq_i,
  input wire logic [MEAS_W-1:0] output_current_i,
  input wire logic [MEAS_W-1:0] output_torque_i,
  input wire logic level_load_i,
  input wire logic [spg_pkg::LEVEL_W-1:0] stall_level_setting_i,
  input wire logic [1:0] stall_quantity_select_i,
  output logic [FREQ_W-1:0] out_freq_o,
  output logic output_enable_o,
  output logic stall_warning_indication_o
);
  spg_cmp_if cmp ();
  spg_pkg::spg_state_e state;
  spg_pkg::spg_state_e next_state;
  logic [spg_pkg::LEVEL_W-1:0] level;
  logic [1:0] qsel;
  logic [31:0] tick_cnt;
  logic tick;
  logic below_set;
  logic above_set;
  logic warn;
  logic [FREQ_W-1:0] freq;
  logic [FREQ_W-1:0] next_freq;
  logic acc_tick;
  logic dec_tick;
  logic drop_tick;
  logic at_set;

  function automatic logic [FREQ_W-1:0] step_up(input logic [FREQ_W-1:0] f, input logic [FREQ_W-1:0] lim);
    step_up = (f < lim) ? f + FREQ_W'(spg_pkg::FREQ_STEP) : lim;
  endfunction : step_up

  function automatic logic [FREQ_W-1:0] step_down(input logic [FREQ_W-1:0] f, input logic [FREQ_W-1:0] lim);
    step_down = (f > lim) ? f - FREQ_W'(spg_pkg::FREQ_STEP) : lim;
  endfunction : step_down

  // one decode for the warning, used on state and next_state alike
  function automatic logic stall_action(input spg_pkg::spg_state_e s);
    stall_action = (s == spg_pkg::SPG_ACC_HOLD) || (s == spg_pkg::SPG_DEC_HOLD)
      || (s == spg_pkg::SPG_CONST_DROP);
  endfunction : stall_action

  assign cmp.current = output_current_i;
  assign cmp.torque = output_torque_i;
  assign cmp.quantity_sel = qsel;
  assign cmp.level = level;

  spg_overload_det u_det (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .cmp(cmp)
  );

  // settings are held so a glitch on the setting bus cannot shift the threshold
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level <= spg_pkg::LEVEL_RESET; // RULE_10
      qsel <= spg_pkg::QSEL_RESET;
    end else if (level_load_i) begin
      level <= stall_level_setting_i;
      qsel <= stall_quantity_select_i;
    end
  end

  assign tick = (tick_cnt == 32'(RAMP_CYCLES - 1));
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  wire logic [FREQ_W-1:0] target = run_i ? set_freq_i : '0;
  assign below_set = freq < target;
  assign above_set = freq > target;
  assign at_set = !below_set && !above_set;
  assign acc_tick = (state == spg_pkg::SPG_ACC) && tick;
  assign dec_tick = (state == spg_pkg::SPG_DEC) && tick;
  assign drop_tick = (state == spg_pkg::SPG_CONST_DROP) && tick;

  always_comb begin
    next_state = state;
    case (state)
      spg_pkg::SPG_IDLE,
      spg_pkg::SPG_CONST: begin
        if (below_set) next_state = spg_pkg::SPG_ACC;
        else if (above_set) next_state = spg_pkg::SPG_DEC;
        else if (cmp.overload && freq != '0) next_state = spg_pkg::SPG_CONST_DROP; // RULE_05
        else if (freq == '0) next_state = spg_pkg::SPG_IDLE;
        else next_state = spg_pkg::SPG_CONST;
      end
      spg_pkg::SPG_ACC: begin
        if (cmp.overload) next_state = spg_pkg::SPG_ACC_HOLD; // RULE_03
        else if (!below_set) next_state = spg_pkg::SPG_CONST;
      end
      spg_pkg::SPG_ACC_HOLD: begin
        if (!cmp.overload) next_state = spg_pkg::SPG_ACC; // RULE_04
        else if (!below_set) next_state = spg_pkg::SPG_CONST;
      end
      spg_pkg::SPG_CONST_DROP: begin
        if (!cmp.overload) next_state = spg_pkg::SPG_ACC; // RULE_06
      end
      spg_pkg::SPG_DEC: begin
        if (cmp.overload) next_state = spg_pkg::SPG_DEC_HOLD; // RULE_07
        else if (!above_set) next_state = spg_pkg::SPG_CONST;
      end
      spg_pkg::SPG_DEC_HOLD: begin
        if (!cmp.overload) next_state = spg_pkg::SPG_DEC; // RULE_08
        else if (!above_set) next_state = spg_pkg::SPG_CONST;
      end
      default: next_state = spg_pkg::SPG_IDLE;
    endcase
  end

  always_comb begin
    next_freq = freq;
    case (state)
      spg_pkg::SPG_ACC: next_freq = tick ? step_up(freq, target) : freq; // RULE_04
      spg_pkg::SPG_DEC: next_freq = tick ? step_down(freq, target) : freq; // RULE_08
      spg_pkg::SPG_CONST_DROP: next_freq = tick ? step_down(freq, '0) : freq; // RULE_05
      spg_pkg::SPG_ACC_HOLD,
      spg_pkg::SPG_DEC_HOLD: next_freq = freq; // RULE_03 RULE_07
      default: next_freq = freq;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= spg_pkg::SPG_IDLE;
      freq <= '0;
    end else begin
      state <= next_state;
      freq <= next_freq;
    end
  end

  assign warn = stall_action(state); // RULE_11

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_freq_o <= '0;
      stall_warning_indication_o <= 1'b0;
      output_enable_o <= 1'b0;
    end else begin
      out_freq_o <= next_freq;
      stall_warning_indication_o <= stall_action(next_state); // RULE_11
      // warning has no say in the enable; output stays on while running
      output_enable_o <= run_i || (next_freq != '0); // RULE_09
    end
  end

  // holds are judged one edge on: the entry edge may still carry a ramp step
  a_acc_hold_freq: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_03
    (state == spg_pkg::SPG_ACC_HOLD) |=> freq == $past(freq))
    else $error("frequency moved during acceleration hold");
  a_dec_hold_freq: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_07
    (state == spg_pkg::SPG_DEC_HOLD) |=> freq == $past(freq))
    else $error("frequency moved during deceleration hold");
  a_hold_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_03
    (state == spg_pkg::SPG_ACC && cmp.overload) |=> state == spg_pkg::SPG_ACC_HOLD)
    else $error("acceleration not held on overload");
  a_dec_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_07
    (state == spg_pkg::SPG_DEC && cmp.overload) |=> state == spg_pkg::SPG_DEC_HOLD)
    else $error("deceleration not held on overload");
  a_drop_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_05
    (state == spg_pkg::SPG_CONST && cmp.overload && at_set && freq != '0) |=> state == spg_pkg::SPG_CONST_DROP)
    else $error("no drop entered at constant speed");
  a_drop_lowers: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_05
    (drop_tick && freq != '0) |=> freq < $past(freq))
    else $error("no drop on overload");
  a_ramp_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_04
    (acc_tick && below_set) |=> freq == $past(freq) + FREQ_W'(spg_pkg::FREQ_STEP))
    else $error("acceleration step missing");
  a_ramp_ceiling: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_04
    acc_tick |=> freq <= $past(target))
    else $error("acceleration overshot the target");
  a_acc_resumes: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_04
    (state == spg_pkg::SPG_ACC_HOLD && !cmp.overload) |=> state == spg_pkg::SPG_ACC)
    else $error("acceleration not resumed");
  a_dec_resumes: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_08
    (state == spg_pkg::SPG_DEC_HOLD && !cmp.overload) |=> state == spg_pkg::SPG_DEC)
    else $error("deceleration not resumed");
  a_dec_floor: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_08
    dec_tick |=> freq >= $past(target))
    else $error("deceleration undershot the target");
  a_const_recovers: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_06
    (state == spg_pkg::SPG_CONST_DROP && !cmp.overload) |=> state == spg_pkg::SPG_ACC)
    else $error("no recovery to set value");
  a_warn_tracks: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_11
    stall_warning_indication_o == warn)
    else $error("warning out of step with action");
  a_warn_rises: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_11
    (state == spg_pkg::SPG_ACC && cmp.overload) |=> stall_warning_indication_o)
    else $error("warning missing on overload");
  a_warn_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_11
    (stall_warning_indication_o && !cmp.overload) |=> !stall_warning_indication_o)
    else $error("warning kept after overload cleared");
  a_output_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_09
    (stall_warning_indication_o && $past(run_i)) |-> output_enable_o)
    else $error("output shut off by warning");
  a_run_enables: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RULE_09
    run_i |=> output_enable_o)
    else $error("output off while running");
  a_level_default: assert property (@(posedge ref_clk_i) // RULE_10
    $rose(rst_b_i) |-> level == spg_pkg::LEVEL_RESET)
    else $error("level default wrong");
endmodule : spg_governor

/* spg_load_model.sv */
// motor and load model: reports current and torque drawn for a demanded load
`timescale 1ns/100ps
module spg_load_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic [15:0] cur_demand_i,
  input wire logic [15:0] trq_demand_i,
  output logic [15:0] current_o,
  output logic [15:0] torque_o
);
  // a motor with no drive output draws nothing, whatever the load
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      current_o <= 16'h0000;
      torque_o <= 16'h0000;
    end else begin
      current_o <= enable_i ? cur_demand_i : 16'h0000;
      torque_o <= enable_i ? trq_demand_i : 16'h0000;
    end
  end
endmodule : spg_load_model

/* tb.sv */
// testbench for the stall prevention governor
`timescale 1ns/100ps
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic run_i = 1'b0;
  logic ld = 1'b0;
  logic [15:0] set_f = 16'h0000;
  logic [15:0] cur_d = 16'h0000;
  logic [15:0] trq_d = 16'h0000;
  logic [9:0] lvl = 10'h096;
  logic [1:0] qsel = 2'h0;
  logic [15:0] cur, trq, freq, f0;
  logic en, warn;
  int err_count = 0;
  int samples_checked = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  spg_load_model spg_load_model_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .enable_i(en),
    .cur_demand_i(cur_d), .trq_demand_i(trq_d), .current_o(cur), .torque_o(trq));
  // short ramp period keeps each ramp to at most 80 cycles
  spg_governor #(.RAMP_CYCLES(4)) spg_governor_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .run_i(run_i),
    .set_freq_i(set_f), .output_current_i(cur), .output_torque_i(trq), .level_load_i(ld),
    .stall_level_setting_i(lvl), .stall_quantity_select_i(qsel), .out_freq_o(freq),
    .output_enable_o(en), .stall_warning_indication_o(warn));
  task finish_test;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  task wait_f(input logic [15:0] t);
    int k;
    for (k = 0; k < 2000 && freq !== t; k++) @(negedge ref_clk_i);
    if (k == 2000) begin
      $display("BAD wait_freq exp %h got %h", t, freq);
      err_count++;
      finish_test();
    end
  endtask : wait_f
  task t_accel;
    run_i = 1'b1;
    set_f = 16'h0014;
    cur_d = 16'h0096;
    cyc(8);
    chk("warn_at_level", 16'h0000, {15'h0, warn});
    cur_d = 16'h0097;
    cyc(5);
    f0 = freq;
    cyc(12);
    chk("acc_hold", f0, freq);
    chk("acc_warn", 16'h0001, {15'h0, warn});
    cur_d = 16'h0064;
    wait_f(16'h0014);
    chk("acc_warn_off", 16'h0000, {15'h0, warn});
  endtask : t_accel
  task t_const;
    cur_d = 16'h00c8;
    cyc(24);
    chk("const_drop", 16'h0001, {15'h0, freq < 16'h0014});
    chk("const_enable", 16'h0001, {15'h0, en});
    chk("const_warn", 16'h0001, {15'h0, warn});
    cur_d = 16'h0064;
    wait_f(16'h0014);
  endtask : t_const
  task t_decel;
    run_i = 1'b0;
    cyc(20);
    cur_d = 16'h00c8;
    cyc(5);
    f0 = freq;
    cyc(12);
    chk("dec_hold", f0, freq);
    chk("dec_warn", 16'h0001, {15'h0, warn});
    cur_d = 16'h0000;
    wait_f(16'h0000);
    chk("idle_enable", 16'h0000, {15'h0, en});
  endtask : t_decel
  task t_torque;
    lvl = 10'h064;
    qsel = 2'h1;
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    run_i = 1'b1;
    set_f = 16'h000a;
    cur_d = 16'h012c;
    trq_d = 16'h0032;
    cyc(12);
    chk("trq_ignore_cur", 16'h0000, {15'h0, warn});
    trq_d = 16'h0096;
    cyc(6);
    chk("trq_overload", 16'h0001, {15'h0, warn});
    qsel = 2'h2;
    ld = 1'b1;
    trq_d = 16'h0000;
    cyc(1);
    ld = 1'b0;
    cyc(6);
    chk("cur_overload", 16'h0001, {15'h0, warn});
    cur_d = 16'h0063;
    wait_f(16'h000a);
  endtask : t_torque
  initial begin
    cyc(10);
    chk("reset_freq", 16'h0000, freq);
    chk("reset_enable", 16'h0000, {15'h0, en});
    rst_b_i = 1'b1;
    cyc(2);
    t_accel();
    t_const();
    t_decel();
    t_torque();
    finish_test();
  end
endmodule : tb
